// File: hdl/abs_pkg.sv
// Package with constants and carrier types for the autobaud serial port
package abs_pkg;
    localparam int TMR_W         = 16;            // Free-running timer width
    localparam int DATA_W        = 8;             // Data bits per byte
    localparam int CAL_BITS      = 8;             // Bit times spanned by calibration
    localparam int DIV8_SHIFT    = 3;             // Shift that divides by eight
    localparam int HALF_SHIFT    = 1;             // Shift that halves the bit period
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;   // Index of last data bit
    localparam logic [TMR_W-1:0] PERIOD_RST = 16'h0000;
    localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;
    localparam logic LINE_IDLE = 1'b1;            // Idle and stop level
    localparam logic LINE_START = 1'b0;           // Start bit level

    // Unit mode: measuring (capture) or bit timing (compare)
    typedef enum logic [1:0] {
        ABS_CAP_FALL = 2'b00,
        ABS_CAP_RISE = 2'b01,
        ABS_COMPARE  = 2'b10
    } abs_mode_t;

    // Transmit byte request
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } abs_tx_req_t;

    // Received byte report
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } abs_rx_byte_t;
endpackage

// File: hdl/abs_bit_timer.sv
// Compare-mode bit timer: counts down the interval, pulses at its end and reloads until stopped
`timescale 1ns/1ns
module abs_bit_timer (
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        start_in,
    input  wire logic                        stop_in,
    input  wire logic [abs_pkg::TMR_W-1:0]   interval_in,
    output logic                             event_out
);
    logic [abs_pkg::TMR_W-1:0] count_ff;
    logic                      run_ff;

    // Reload on start, pulse when the count runs out, then reload for the next bit
    always_ff @(posedge clk_in) begin
        if (srst_in || stop_in) begin
            count_ff <= abs_pkg::PERIOD_RST;
            run_ff   <= 1'b0;
        end else if (start_in) begin
            count_ff <= interval_in;
            run_ff   <= 1'b1;
        end else if (run_ff) begin
            if (count_ff <= 16'h0001) begin
                count_ff <= interval_in;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end
    end

    // Event ignores stop_in: the transmit caller derives stop from this event, so gating it would loop
    assign event_out = run_ff && !start_in && (count_ff <= 16'h0001);
endmodule

// File: hdl/abs_autobaud_serial.sv
// Timer-based serial port that measures bit rate then moves bytes
`timescale 1ns/1ns
module abs_autobaud_serial (
    input  wire logic                  clk_in,
    input  wire logic                  srst_in,
    input  wire logic                  recal_in,
    input  wire logic                  receive_line_in,
    input  wire abs_pkg::abs_tx_req_t  tx_req_in,
    output logic                       tx_ready_out,
    output logic                       transmit_line_out,
    output abs_pkg::abs_rx_byte_t      rx_byte_out,
    output logic                       rate_valid_out,
    output logic [abs_pkg::TMR_W-1:0]  bit_period_out
);
    typedef enum logic [2:0] {
        ABS_IDLE  = 3'b000,
        ABS_START = 3'b001,
        ABS_DATA  = 3'b010,
        ABS_STOP  = 3'b011,
        ABS_FIRST = 3'b100
    } abs_seq_t;

    abs_pkg::abs_mode_t        mode_ff;
    logic [abs_pkg::TMR_W-1:0] free_tmr_ff;
    logic [abs_pkg::TMR_W-1:0] captured_timer_value_ff;
    logic [abs_pkg::TMR_W-1:0] bit_period_ff;
    logic [abs_pkg::TMR_W-1:0] eight_bit_time;
    logic                      rx_prev_ff;
    logic                      fall_edge;
    logic                      rise_edge;

    abs_seq_t                  tx_st_ff;
    logic [3:0]                tx_idx_ff;
    logic [abs_pkg::DATA_W-1:0] tx_shift_ff;
    logic                      tx_line_ff;
    logic                      tx_start;
    logic                      tx_evt;

    abs_seq_t                  rx_st_ff;
    logic [3:0]                rx_idx_ff;
    logic [abs_pkg::DATA_W-1:0] rx_shift_ff;
    abs_pkg::abs_rx_byte_t     rx_byte_ff;
    logic                      rx_start;
    logic                      rx_evt;
    logic                      rx_first;
    logic [abs_pkg::TMR_W-1:0] rx_interval;

    // Edge detection on the receive line
    assign fall_edge = rx_prev_ff && !receive_line_in;
    assign rise_edge = !rx_prev_ff && receive_line_in;
    assign eight_bit_time = receive_line_in ? (free_tmr_ff - captured_timer_value_ff)
                                            : abs_pkg::PERIOD_RST;

    // Free-running timer and previous line level
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            free_tmr_ff <= abs_pkg::PERIOD_RST;
            rx_prev_ff  <= abs_pkg::LINE_IDLE;
        end else begin
            free_tmr_ff <= free_tmr_ff + 16'h0001;
            rx_prev_ff  <= receive_line_in;
        end
    end

    // Capture sequence then switch to compare mode; recal rearms capture
    always_ff @(posedge clk_in) begin
        if (srst_in || recal_in) begin
            mode_ff                 <= abs_pkg::ABS_CAP_FALL;
            captured_timer_value_ff <= abs_pkg::PERIOD_RST;
            bit_period_ff           <= abs_pkg::PERIOD_RST;
        end else begin
            case (mode_ff)
                abs_pkg::ABS_CAP_FALL: begin
                    if (fall_edge) begin
                        captured_timer_value_ff <= free_tmr_ff;
                        mode_ff <= abs_pkg::ABS_CAP_RISE;
                    end
                end
                abs_pkg::ABS_CAP_RISE: begin
                    if (rise_edge) begin
                        bit_period_ff <= eight_bit_time >> abs_pkg::DIV8_SHIFT;
                        mode_ff <= abs_pkg::ABS_COMPARE;
                    end
                end
                abs_pkg::ABS_COMPARE: begin
                    mode_ff <= abs_pkg::ABS_COMPARE;
                end
                default: begin
                    mode_ff <= abs_pkg::ABS_CAP_FALL;
                end
            endcase
        end
    end

    assign rate_valid_out = (mode_ff == abs_pkg::ABS_COMPARE);
    assign bit_period_out = bit_period_ff;

    // Transmit timer: one event per bit period
    assign tx_ready_out = rate_valid_out && (tx_st_ff == ABS_IDLE);
    assign tx_start     = tx_ready_out && tx_req_in.valid;

    abs_bit_timer u_tx_timer (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .start_in    (tx_start),
        .stop_in     (recal_in || (tx_st_ff == ABS_STOP && tx_evt)),
        .interval_in (bit_period_ff),
        .event_out   (tx_evt)
    );

    // Transmit sequencer: start, eight data bits, stop
    always_ff @(posedge clk_in) begin
        if (srst_in || recal_in) begin
            tx_st_ff    <= ABS_IDLE;
            tx_idx_ff   <= 4'h0;
            tx_shift_ff <= abs_pkg::BYTE_RST;
            tx_line_ff  <= abs_pkg::LINE_IDLE;
        end else begin
            case (tx_st_ff)
                ABS_IDLE: begin
                    if (tx_start) begin
                        tx_shift_ff <= tx_req_in.data;
                        tx_line_ff  <= abs_pkg::LINE_START;
                        tx_idx_ff   <= 4'h0;
                        tx_st_ff    <= ABS_DATA;
                    end
                end
                ABS_DATA: begin
                    if (tx_evt) begin
                        tx_line_ff  <= tx_shift_ff[0];
                        tx_shift_ff <= tx_shift_ff >> 1;
                        tx_idx_ff   <= tx_idx_ff + 4'h1;
                        if (tx_idx_ff == abs_pkg::BIT_CNT_LAST) begin
                            tx_st_ff <= ABS_STOP;
                        end
                    end
                end
                ABS_STOP: begin
                    if (tx_evt) begin
                        tx_line_ff <= abs_pkg::LINE_IDLE;
                        tx_st_ff   <= ABS_IDLE;
                    end
                end
                default: begin
                    tx_st_ff <= ABS_IDLE;
                end
            endcase
        end
    end

    assign transmit_line_out = tx_line_ff;

    // Receive timer: half plus one period to first sample, then one period
    assign rx_start    = rate_valid_out && (rx_st_ff == ABS_IDLE) && !receive_line_in;
    assign rx_first    = (rx_st_ff == ABS_IDLE);
    assign rx_interval = rx_first
                         ? (bit_period_ff + (bit_period_ff >> abs_pkg::HALF_SHIFT))
                         : bit_period_ff;

    abs_bit_timer u_rx_timer (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .start_in    (rx_start),
        .stop_in     (recal_in || (rx_st_ff == ABS_FIRST)),
        .interval_in (rx_interval),
        .event_out   (rx_evt)
    );

    // Receive sequencer: sample eight bits LSB first
    always_ff @(posedge clk_in) begin
        if (srst_in || recal_in) begin
            rx_st_ff    <= ABS_IDLE;
            rx_idx_ff   <= 4'h0;
            rx_shift_ff <= abs_pkg::BYTE_RST;
            rx_byte_ff  <= '0;
        end else begin
            rx_byte_ff.valid <= 1'b0;
            case (rx_st_ff)
                ABS_IDLE: begin
                    if (rx_start) begin
                        rx_idx_ff <= 4'h0;
                        rx_st_ff  <= ABS_DATA;
                    end
                end
                ABS_DATA: begin
                    if (rx_evt) begin
                        rx_shift_ff <= {receive_line_in, rx_shift_ff[7:1]};
                        rx_idx_ff   <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff == abs_pkg::BIT_CNT_LAST) begin
                            rx_byte_ff.valid <= 1'b1;
                            rx_byte_ff.data  <= {receive_line_in, rx_shift_ff[7:1]};
                            rx_st_ff <= ABS_FIRST;
                        end
                    end
                end
                ABS_FIRST: begin
                    // Timer stops here; wait for line high before rearming
                    if (receive_line_in) begin
                        rx_st_ff <= ABS_IDLE;
                    end
                end
                default: begin
                    rx_st_ff <= ABS_IDLE;
                end
            endcase
        end
    end

    assign rx_byte_out = rx_byte_ff;
endmodule

// File: test/abs_autobaud_serial_asserts.sv
// Port assertions for the autobaud serial port
`timescale 1ns/1ns
module abs_checker (
    input wire logic                      clk_in,
    input wire logic                      srst_in,
    input wire logic                      recal_in,
    input wire logic                      receive_line_in,
    input wire abs_pkg::abs_tx_req_t      tx_req_in,
    input wire logic                      tx_ready_out,
    input wire logic                      transmit_line_out,
    input wire abs_pkg::abs_rx_byte_t     rx_byte_out,
    input wire logic                      rate_valid_out,
    input wire logic [abs_pkg::TMR_W-1:0] bit_period_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // Transmit request accepted this cycle
    logic take;
    assign take = tx_req_in.valid && tx_ready_out && !recal_in;
    AST_RST_IDLE: assert property ($fell(srst_in) |-> transmit_line_out)
        else $error("line not idle after reset");
    AST_READY_RATE: assert property (tx_ready_out |-> rate_valid_out)
        else $error("ready before calibration");
    AST_START_BIT: assert property (take |=> !transmit_line_out && !tx_ready_out)
        else $error("no start bit");
    AST_TX_HOLD: assert property (take |=> !tx_ready_out [*8])
        else $error("frame ended early");
    AST_RECAL: assert property (recal_in |=> !rate_valid_out && !tx_ready_out)
        else $error("recal ignored");
    AST_RATE_RISE: assert property ($rose(rate_valid_out) |->
        $past(receive_line_in) && !$past(receive_line_in, 2)) else $error("rate without rise");
    AST_PERIOD_HOLD: assert property (rate_valid_out && !recal_in |=> $stable(bit_period_out))
        else $error("period changed");
    AST_RX_PULSE: assert property (rx_byte_out.valid |=> !rx_byte_out.valid)
        else $error("rx valid too long");
    // Main scenarios reached
    cover property (take);
    cover property (rx_byte_out.valid);
    cover property ($rose(rate_valid_out));
endmodule
bind abs_autobaud_serial abs_checker abs_checker_inst (.clk_in, .srst_in, .recal_in,
    .receive_line_in, .tx_req_in, .tx_ready_out, .transmit_line_out, .rx_byte_out,
    .rate_valid_out, .bit_period_out);

// File: test/abs_remote_model.sv
// Remote serial party: sends calibration and data frames, idles high
`timescale 1ns/1ns
module abs_remote_model (
    input  wire logic clk_in,
    output logic      line_out
);
    initial line_out = 1'h1;
    // Drive a level for a number of clock cycles
    task automatic hold(input logic lvl, input int n);
        line_out <= lvl;
        repeat (n) @(posedge clk_in);
    endtask
    // Calibration character: one low run spanning eight bit times
    task automatic send_cal(input int low);
        hold(1'h0, low);
        hold(1'h1, 40);
    endtask
    // Data frame: start, eight bits LSB first, stop
    task automatic send_byte(input logic [7:0] d, input int p);
        hold(1'h0, p);
        for (int i = 0; i < 8; i++) hold(d[i], p);
        hold(1'h1, 2 * p);
    endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the autobaud serial port
`timescale 1ns/1ns
module tb;
    logic                  clk_in;
    logic                  srst_in = 1'h1;
    logic                  recal_in = 1'h0;
    logic                  rx_line;
    abs_pkg::abs_tx_req_t  tx_req = '0;
    logic                  tx_ready;
    logic                  tx_line;
    abs_pkg::abs_rx_byte_t rx_byte;
    logic                  rate_valid;
    logic [15:0]           bit_period;
    int                    num_errors = 0;
    int                    num_checks = 0;
    int                    p;
    // Each byte is sent and received; it is also its own expected result
    logic [7:0]            rows [4] = '{8'h55, 8'h00, 8'hff, 8'ha3};
    // Clock generator
    initial begin
        clk_in = 1'h0;
        forever #4 clk_in = ~clk_in;
    end
    abs_autobaud_serial abs_autobaud_serial_inst (.clk_in, .srst_in, .recal_in,
        .receive_line_in(rx_line), .tx_req_in(tx_req), .tx_ready_out(tx_ready),
        .transmit_line_out(tx_line), .rx_byte_out(rx_byte), .rate_valid_out(rate_valid),
        .bit_period_out(bit_period));
    abs_remote_model abs_remote_model_inst (.clk_in, .line_out(rx_line));
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and stop
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Send a calibration run of the given length and check the derived period
    task automatic calibrate(input int np, input int low);
        p = np;
        @(posedge clk_in);
        abs_remote_model_inst.send_cal(low);
        @(negedge clk_in);
        check(rate_valid, 1'h1);
        check(bit_period, 16'(low >> 3));
    endtask
    // Transmit one byte and sample the line mid-bit
    task automatic send_tx(input logic [7:0] d);
        repeat (p) @(negedge clk_in);
        check(tx_ready, 1'h1);
        @(posedge clk_in);
        tx_req <= '{valid: 1'h1, data: d};
        @(posedge clk_in);
        tx_req.valid <= 1'h0;
        repeat (p / 2) @(negedge clk_in);
        check(tx_line, 1'h0);
        for (int i = 0; i < 9; i++) begin
            repeat (p) @(negedge clk_in);
            check(tx_line, i < 8 ? d[i] : 1'h1);
        end
    endtask
    // Remote sends one byte; wait a bounded time for the report
    task automatic rx_one(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        fork
            abs_remote_model_inst.send_byte(d, p);
            while (rx_byte.valid !== 1'h1) begin
                @(negedge clk_in);
                n++;
                if (n > 20 * p) begin
                    num_errors++;
                    end_of_test();
                end
            end
        join
        check(rx_byte.data, d);
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        srst_in <= 1'h0;
        tx_req <= '{valid: 1'h1, data: 8'h5a};
        repeat (4) @(negedge clk_in);
        check(tx_line, 1'h1);
        check(tx_ready, 1'h0);
        check(bit_period, 16'h0000);
        @(posedge clk_in);
        tx_req.valid <= 1'h0;
        calibrate(16, 135);
        foreach (rows[i]) begin
            send_tx(rows[i]);
            rx_one(rows[i]);
        end
        // Remote runs one clock per bit slow; each sample drifts one clock earlier per bit but must stay inside its bit
        p = p + 1;
        rx_one(8'h96);
        // Reconfigure in mid-frame, then measure a new rate
        @(posedge clk_in);
        tx_req <= '{valid: 1'h1, data: 8'h0f};
        repeat (5) @(posedge clk_in);
        tx_req.valid <= 1'h0;
        recal_in <= 1'h1;
        @(posedge clk_in);
        recal_in <= 1'h0;
        @(negedge clk_in);
        check(rate_valid, 1'h0);
        calibrate(10, 80);
        send_tx(8'h3c);
        rx_one(8'hc3);
        end_of_test();
    end
endmodule
